// ### verilog/srrs_regs.svh
// register offsets, shadow indices, reset values and wait constants of the sequencer
`ifndef SRRS_REGS_SVH
`define SRRS_REGS_SVH
// ==========================================
// bus offsets (byte addresses, low 12 bits)
`define SRRS_OFS_STATUS 12'h000
`define SRRS_OFS_STAB 12'h004
`define SRRS_OFS_CMD 12'h008
`define SRRS_OFS_PC 12'h00C
// shadow page: offset 0x100 + 4 * index
`define SRRS_SHADOW_PAGE 4'h1
// ==========================================
// shadow indices; order:
// 00 flags word, 01 clock ctrl, 02 port latch, 03 port dir, 04 pullup a, 05 pullup b,
// 06/07 wide count, 08/09 wide compare, 0A wide mode, 0B buzzer, 0C byte count,
// 0D byte mode, 0E wd clock, 0F wd mode, 10 sync mode, 11 async mode, 12 async status,
// 13 baud ctrl, 14 tx shifter, 15/16 req flags, 17/18 masks, 19 edge mode,
// 1A stack ptr, 1B wide capture, 1C byte compare, 1D rx buffer (1A to 1D no reset value)
`define SRRS_SHADOW_NUM 5'h1E
`define SRRS_RST_NUM 5'h1A
`define SRRS_IDX_PSW 5'h00
`define SRRS_IDX_PCC 5'h01
`define SRRS_IDX_PDIR 5'h03
`define SRRS_IDX_WCMP_LO 5'h08
`define SRRS_IDX_WCMP_HI 5'h09
`define SRRS_IDX_TXS 5'h14
`define SRRS_IDX_MK_LO 5'h17
`define SRRS_IDX_MK_HI 5'h18
// ==========================================
// reset values
`define SRRS_RV_PSW 8'h02
`define SRRS_RV_PCC 8'h02
`define SRRS_RV_ONES 8'hFF
`define SRRS_RV_ZERO 8'h00
`define SRRS_RV_STAB 3'h4
// ==========================================
// stabilization select encodings and waits, exponent n of 2^n/fx (fx = core_clk)
`define SRRS_SEL_SHORT 3'h0
`define SRRS_SEL_MID 3'h2
`define SRRS_SEL_LONG 3'h4
`define SRRS_STAB_SHORT_EXP 12
`define SRRS_STAB_MID_EXP 15
`define SRRS_STAB_LONG_EXP 17
`endif

// ### verilog/srrs_pkg.sv
// types of the stop release and reset sequencer
package srrs_pkg;
   // one-hot sequencer states
   typedef enum logic [3:0] {
      SRRS_RUN = 4'h1,
      SRRS_STOP = 4'h2,
      SRRS_RESET = 4'h4,
      SRRS_WAIT = 4'h8
   } srrs_state_t;
endpackage : srrs_pkg

// ### verilog/srrs_sequencer.sv
// stop release and system reset sequencer with ahb-lite register slave
// Behaviour
// - irq wake waits, then services or continues
// - mask 0 wakes; ie picks service; mask 1 stays
// - reset ends stop, waits, then reset processing
// - pin and watchdog give identical system reset
// - program counter loads from vector at 0000H/0001H
// - low pin holds reset; release after wait
// - watchdog reset clears itself, then waits
// - pins high impedance during reset and wait
// - reset from stop keeps contents held
// - counter undefined during reset and wait
// - flags word takes 02H on reset
// - latches zero, directions input, pullups zero
// - clock control 02H, stabilization select 04H
// - wide timer count 0, compare ones, modes 0
// - byte timer count and mode clear
// - watchdog clock and mode registers clear
// - serial modes zero, tx shifter ones
// - request flags zero, masks all ones
// - reset in standby preserves ram contents
// - select resets longest; pin release uses middle
// - wait counts only after oscillator restarts
//
// Implementation choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "srrs_regs.svh"
module srrs_sequencer
   import srrs_pkg::*;
#(
   parameter int unsigned STAB_MID_CYC = 1 << `SRRS_STAB_MID_EXP,
   parameter int unsigned STAB_LONG_CYC = 1 << `SRRS_STAB_LONG_EXP
) (
   input wire logic core_clk,
   input wire logic nrst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // pins and partners
   input wire logic reset_pin_n,
   input wire logic osc_ready,
   input wire logic wdt_overflow,
   input wire logic irq_request,
   input wire logic interrupt_mask_flag,
   input wire logic interrupt_acknowledge_enable,
   input wire logic [7:0] vector_lo,
   input wire logic [7:0] vector_hi,
   // sequencer outputs
   output logic osc_stop,
   output logic system_reset,
   output logic pins_hiz,
   output logic ram_hold,
   output logic cpu_run,
   output logic resume_next,
   output logic service_irq,
   output logic pc_valid,
   output logic [15:0] program_counter,
   output logic [2:0] stab_time_select
);
   // ==========================================
   // functions
   // wait length in cycles minus one for a select and cause
   function automatic logic [17:0] wait_last(input logic [2:0] sel, input logic by_rst);
      logic [17:0] r;
      r = 18'((1 << `SRRS_STAB_SHORT_EXP) - 1);
      if (by_rst || sel == `SRRS_SEL_MID) begin
         r = 18'(STAB_MID_CYC - 1);
      end else if (sel == `SRRS_SEL_LONG) begin
         r = 18'(STAB_LONG_CYC - 1);
      end
      return r;
   endfunction : wait_last
   // reset value of a shadow register
   function automatic logic [7:0] rst_val(input logic [4:0] idx);
      logic [7:0] v;
      case (idx)
         `SRRS_IDX_PSW: v = `SRRS_RV_PSW;
         `SRRS_IDX_PCC: v = `SRRS_RV_PCC;
         `SRRS_IDX_PDIR, `SRRS_IDX_WCMP_LO, `SRRS_IDX_WCMP_HI,
         `SRRS_IDX_TXS, `SRRS_IDX_MK_LO, `SRRS_IDX_MK_HI: v = `SRRS_RV_ONES;
         default: v = `SRRS_RV_ZERO;
      endcase
      return v;
   endfunction : rst_val
   // ==========================================
   // declarations
   srrs_state_t state; // sequencer state
   srrs_state_t next_state; // next state
   logic pin_s1; // reset pin first stage
   logic pin_s2; // reset pin synchronised
   logic osc_s1; // oscillator ready first stage
   logic osc_s2; // oscillator ready synchronised
   logic wait_rst; // current wait follows a reset
   logic [17:0] stab_cnt; // stabilization counter
   logic [7:0] shadow [0:`SRRS_SHADOW_NUM-1]; // peripheral registers
   logic wr_pend; // write data phase pending
   logic [11:0] wr_addr; // address of pending write
   logic [31:0] rd_data; // read mux value
   logic next_sys_rst; // system reset next cycle
   // ==========================================
   // decode
   wire rst_event = !pin_s2 || wdt_overflow; // any reset source
   wire wake = irq_request && !interrupt_mask_flag; // unmasked request
   // wait ends only while the oscillator runs, a stalled start never finishes it
   wire stab_done = state == SRRS_WAIT && osc_s2 &&
                    stab_cnt == wait_last(stab_time_select, wait_rst);
   wire acc = hsel && htrans[1] && hready; // transfer taken
   wire [4:0] rd_idx = haddr[6:2]; // shadow index of address phase
   wire rd_shadow = haddr[11:8] == `SRRS_SHADOW_PAGE && haddr[7] == 1'b0 &&
                    rd_idx < `SRRS_SHADOW_NUM;
   wire [4:0] wr_idx = wr_addr[6:2]; // shadow index of data phase
   wire wr_shadow = wr_pend && wr_addr[11:8] == `SRRS_SHADOW_PAGE &&
                    wr_addr[7] == 1'b0 && wr_idx < `SRRS_SHADOW_NUM;
   wire wr_stab = wr_pend && wr_addr == `SRRS_OFS_STAB;
   wire stab_legal = hwdata[2:0] == `SRRS_SEL_SHORT || hwdata[2:0] == `SRRS_SEL_MID ||
                     hwdata[2:0] == `SRRS_SEL_LONG;
   wire stop_req = wr_pend && wr_addr == `SRRS_OFS_CMD && hwdata[0];
   wire [15:0] vec_word = {vector_hi, vector_lo}; // reset vector, low byte first
   wire [31:0] status_word = {25'h0, osc_s2, ram_hold, wait_rst, state};
   // read data selection
   assign rd_data = rd_shadow ? {24'h0, shadow[rd_idx]} :
                    haddr[11:0] == `SRRS_OFS_STATUS ? status_word :
                    haddr[11:0] == `SRRS_OFS_STAB ? {29'h0, stab_time_select} :
                    haddr[11:0] == `SRRS_OFS_PC ? {16'h0, program_counter} : 32'h0;
   // ==========================================
   // pin synchronisers
   // only the second stage is read by logic, the first may be metastable
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
         osc_s1 <= 1'b0;
         osc_s2 <= 1'b0;
      end else begin
         pin_s1 <= reset_pin_n;
         pin_s2 <= pin_s1;
         osc_s1 <= osc_ready;
         osc_s2 <= osc_s1;
      end
   end
   // ==========================================
   // state machine
   always_comb begin
      next_state = state;
      case (state)
         SRRS_RUN: begin
            if (rst_event) begin
               next_state = SRRS_RESET;
            end else if (stop_req) begin
               next_state = SRRS_STOP;
            end
         end
         SRRS_STOP: begin
            if (rst_event) begin
               next_state = SRRS_RESET;
            end else if (wake) begin
               next_state = SRRS_WAIT;
            end
         end
         SRRS_RESET: begin
            if (pin_s2) begin
               next_state = SRRS_WAIT;
            end
         end
         SRRS_WAIT: begin
            if (rst_event) begin
               next_state = SRRS_RESET;
            end else if (stab_done) begin
               next_state = SRRS_RUN;
            end
         end
         // an illegal code falls back to reset
         default: next_state = SRRS_RESET;
      endcase
   end
   assign next_sys_rst = next_state == SRRS_RESET || (next_state == SRRS_WAIT &&
                         (wait_rst || state == SRRS_RESET));
   // state and cause
   // the cause is kept so a post-reset wait always takes the middle length
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         state <= SRRS_RESET;
         wait_rst <= 1'b1;
      end else begin
         state <= next_state;
         if (next_state == SRRS_RESET) begin
            wait_rst <= 1'b1;
         end else if (next_state == SRRS_RUN) begin
            wait_rst <= 1'b0;
         end
      end
   end
   // ==========================================
   // stabilization counter
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         stab_cnt <= 18'h0;
      end else if (state != SRRS_WAIT || rst_event) begin
         stab_cnt <= 18'h0;
      end else if (osc_s2) begin
         stab_cnt <= stab_cnt + 18'h1;
      end
   end
   // ==========================================
   // registered sequencer outputs
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         osc_stop <= 1'b1;
         system_reset <= 1'b1;
         pins_hiz <= 1'b1;
         cpu_run <= 1'b0;
      end else begin
         osc_stop <= next_state == SRRS_STOP || next_state == SRRS_RESET;
         system_reset <= next_sys_rst;
         pins_hiz <= next_sys_rst;
         cpu_run <= next_state == SRRS_RUN;
      end
   end
   // reset from stop holds standby contents
   // the hold ends only when execution resumes, so a repeated reset keeps it
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ram_hold <= 1'b0;
      end else if (state == SRRS_STOP && rst_event) begin
         ram_hold <= 1'b1;
      end else if (next_state == SRRS_RUN) begin
         ram_hold <= 1'b0;
      end
   end
   // wake outcome pulses and counter load
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         resume_next <= 1'b0;
         service_irq <= 1'b0;
         pc_valid <= 1'b0;
         program_counter <= 16'h0;
      end else begin
         resume_next <= 1'b0;
         service_irq <= 1'b0;
         if (next_sys_rst) begin
            pc_valid <= 1'b0;
         end
         if (next_state == SRRS_RUN && state == SRRS_WAIT) begin
            if (wait_rst) begin
               program_counter <= vec_word;
               pc_valid <= 1'b1;
            end else begin
               service_irq <= interrupt_acknowledge_enable;
               resume_next <= !interrupt_acknowledge_enable;
            end
         end
      end
   end
   // ==========================================
   // peripheral registers and stabilization select
   always_ff @(posedge core_clk) begin
      if (!nrst || next_sys_rst) begin
         stab_time_select <= `SRRS_RV_STAB;
      end else if (wr_stab && stab_legal) begin
         stab_time_select <= hwdata[2:0];
      end
   end
   // reset forces table values, undefined entries keep contents
   always_ff @(posedge core_clk) begin
      if (!nrst || next_sys_rst) begin
         for (int i = 0; i < `SRRS_RST_NUM; i++) begin
            shadow[i] <= rst_val(5'(i));
         end
      end else if (wr_shadow) begin
         shadow[wr_idx] <= hwdata[7:0];
      end
   end
   // ==========================================
   // ahb-lite slave, zero wait states
   // read data is registered at the address edge; writes land at the data-phase edge
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0;
         wr_pend <= 1'b0;
         wr_addr <= 12'h0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend <= acc && hwrite;
         wr_addr <= haddr[11:0];
         // unmapped reads give zero
         hrdata <= (acc && !hwrite) ? rd_data : 32'h0;
      end
   end
   // ==========================================
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   sequence s_stop_woken;
      state == SRRS_STOP && wake && !rst_event;
   endsequence
   sequence s_wait_entry;
      state == SRRS_WAIT && stab_cnt == 18'h0;
   endsequence
   a_irq_wake_wait: assert property (s_stop_woken |=> s_wait_entry and !cpu_run)
      else $error("irq wake did not start stabilization wait");
   a_irq_outcome: assert property (stab_done && !wait_rst && !rst_event |=>
      service_irq == $past(interrupt_acknowledge_enable) && resume_next != service_irq)
      else $error("wrong wake outcome");
   a_mask_stays: assert property (state == SRRS_STOP && !wake && !rst_event && !stop_req
      |=> state == SRRS_STOP && osc_stop)
      else $error("masked request left stop");
   a_stop_reset: assert property (state == SRRS_STOP && rst_event |=>
      system_reset && ram_hold)
      else $error("reset from stop not taken");
   a_wdt_reset: assert property (wdt_overflow |=> system_reset && pins_hiz)
      else $error("watchdog overflow gave no reset");
   a_pin_hold: assert property (!pin_s2 ##1 !pin_s2 |-> state == SRRS_RESET)
      else $error("low pin not holding reset");
   a_wdt_clears: assert property (state == SRRS_RESET && pin_s2 |=>
      state == SRRS_WAIT && system_reset)
      else $error("reset did not release into wait");
   a_vector_load: assert property (stab_done && wait_rst && !rst_event |=>
      pc_valid && program_counter == $past(vec_word) && !system_reset)
      else $error("program counter not loaded from vector");
   a_pins_float: assert property (system_reset |-> pins_hiz && !pc_valid)
      else $error("pins driven or counter valid during reset");
   a_reset_values: assert property (system_reset |-> stab_time_select == `SRRS_RV_STAB
      && shadow[`SRRS_IDX_MK_LO] == `SRRS_RV_ONES
      && shadow[`SRRS_IDX_PSW] == `SRRS_RV_PSW)
      else $error("registers not at reset values");
   a_mid_wait: assert property (state == SRRS_WAIT && wait_rst && osc_s2 && !rst_event
      && stab_cnt < 18'(STAB_MID_CYC - 1) |=> state == SRRS_WAIT)
      else $error("post-reset wait ended early");
   a_osc_gate: assert property (state == SRRS_WAIT && !osc_s2 && !rst_event
      |=> $stable(stab_cnt))
      else $error("wait counted before oscillator restart");
   a_cnt_restart: assert property (state != SRRS_WAIT |=> stab_cnt == 18'h0)
      else $error("stabilization counter not restarted");
   // reset inside the wait restarts it
   a_wait_reset: assert property (state == SRRS_WAIT && rst_event |=>
      state == SRRS_RESET && stab_cnt == 18'h0)
      else $error("reset during wait did not restart");
   a_pulse_once: assert property (service_irq || resume_next |=>
      !service_irq && !resume_next)
      else $error("wake outcome pulse held too long");
endmodule : srrs_sequencer

// ### verif/srrs_far_side.sv
// far side model: oscillator start, watchdog overflow and reset vector memory
`timescale 1ns/1ps
module srrs_far_side (
   input wire logic core_clk,
   input wire logic osc_stop,
   input wire logic [3:0] start_delay,
   input wire logic wd_fire,
   input wire logic [15:0] vector,
   output logic osc_ready,
   output logic wdt_overflow,
   output logic [7:0] vector_lo,
   output logic [7:0] vector_hi
);
   // ==========================================
   // oscillator
   logic [3:0] start_cnt; // cycles since the stop was lifted
   logic wd_q; // last request from the bench
   always_ff @(posedge core_clk) begin
      if (osc_stop) begin
         start_cnt <= 4'h0;
         osc_ready <= 1'b0;
      end else if (start_cnt < start_delay) begin
         start_cnt <= start_cnt + 4'h1;
      end else begin
         osc_ready <= 1'b1;
      end
   end
   // ==========================================
   // watchdog
   // one overflow pulse
   always_ff @(posedge core_clk) begin
      wd_q <= wd_fire;
      wdt_overflow <= wd_fire & ~wd_q;
   end
   assign vector_lo = vector[7:0];
   assign vector_hi = vector[15:8];
endmodule : srrs_far_side

// ### verif/testbench.sv
// self-checking bench of the stop release and reset sequencer
`timescale 1ns/1ps
`include "srrs_regs.svh"
module testbench;
   // ==========================================
   // settings and signals
   localparam int MID = 16; // shortened middle wait
   localparam int LONG = 32; // shortened longest wait
   localparam int SHORT = 4096; // fixed short wait
   localparam int PIN_MIN = 4; // scaled minimum pin pulse
   logic core_clk, nrst, hsel, hwrite, hreadyout, hresp, wd_fire;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize, stab_time_select;
   logic reset_pin_n, osc_ready, wdt_overflow, irq_request;
   logic interrupt_mask_flag, interrupt_acknowledge_enable;
   logic osc_stop, system_reset, pins_hiz, ram_hold, cpu_run, resume_next, service_irq, pc_valid;
   logic [7:0] vector_lo, vector_hi;
   logic [15:0] program_counter, vec;
   logic [3:0] start_delay;
   int shadow_m[30]; // expected shadow contents
   bit known_m[30]; // shadow has a defined value
   int stab_m; // expected select
   int seed = 91;
   int fails = 0;
   int check_count = 0;
   srrs_sequencer #(.STAB_MID_CYC(MID), .STAB_LONG_CYC(LONG)) i_dut (.core_clk(core_clk),
      .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .reset_pin_n(reset_pin_n), .osc_ready(osc_ready),
      .wdt_overflow(wdt_overflow), .irq_request(irq_request),
      .interrupt_mask_flag(interrupt_mask_flag),
      .interrupt_acknowledge_enable(interrupt_acknowledge_enable), .vector_lo(vector_lo),
      .vector_hi(vector_hi), .osc_stop(osc_stop), .system_reset(system_reset),
      .pins_hiz(pins_hiz), .ram_hold(ram_hold), .cpu_run(cpu_run),
      .resume_next(resume_next), .service_irq(service_irq), .pc_valid(pc_valid),
      .program_counter(program_counter), .stab_time_select(stab_time_select));
   srrs_far_side i_far (.core_clk(core_clk), .osc_stop(osc_stop), .start_delay(start_delay),
      .wd_fire(wd_fire), .vector(vec), .osc_ready(osc_ready), .wdt_overflow(wdt_overflow),
      .vector_lo(vector_lo), .vector_hi(vector_hi));
   always #5 core_clk = ~core_clk;
   // ==========================================
   // comparison and closing
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_range(input int got, input int lo, input int hi);
      check_count++;
      if (got < lo || got > hi) begin
         fails++;
         $display("BAD %0t wait of %0d cycles outside %0d..%0d", $time, got, lo, hi);
      end
   endtask : chk_range
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : conclude
   task automatic give_up();
      fails++;
      $display("BAD %0t wait ran out", $time);
      conclude();
   endtask : give_up
   // ==========================================
   // model of the register contents
   function automatic int rst_val(input int i);
      case (i)
         `SRRS_IDX_PSW: return `SRRS_RV_PSW;
         `SRRS_IDX_PCC: return `SRRS_RV_PCC;
         `SRRS_IDX_PDIR, `SRRS_IDX_WCMP_LO, `SRRS_IDX_WCMP_HI: return `SRRS_RV_ONES;
         `SRRS_IDX_TXS, `SRRS_IDX_MK_LO, `SRRS_IDX_MK_HI: return `SRRS_RV_ONES;
         default: return `SRRS_RV_ZERO;
      endcase
   endfunction : rst_val
   task automatic model_reset();
      for (int i = 0; i < 30; i++) begin
         shadow_m[i] = rst_val(i);
         known_m[i] = (i < `SRRS_RST_NUM);
      end
      stab_m = 4;
   endtask : model_reset
   function automatic logic [31:0] expect_rd(input logic [31:0] a);
      if (a == `SRRS_OFS_STAB) return stab_m;
      if (a >= 32'h100 && a < 32'h178) return shadow_m[(a - 32'h100) >> 2];
      return 32'h0;
   endfunction : expect_rd
   // ==========================================
   // bus master: hready sampled at each rising edge, changes made right after it
   task automatic sync_ready();
      int k;
      k = 0;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) begin
         @(posedge core_clk);
         k++;
         if (k > 50) give_up();
      end
   endtask : sync_ready
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      sync_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      sync_ready();
      rd = hrdata;
      chk(hresp, 1'b0);
   endtask : bus
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      if (a == `SRRS_OFS_STAB && d inside {0, 2, 4}) stab_m = d;
      if (a >= 32'h100 && a < 32'h178) begin
         shadow_m[(a - 32'h100) >> 2] = d & 255;
         known_m[(a - 32'h100) >> 2] = 1'b1;
      end
   endtask : wr
   task automatic rd_chk(input logic [31:0] a);
      bus(1'b0, a, $random(seed));
      chk(rd, expect_rd(a));
   endtask : rd_chk
   task automatic chk_regs();
      for (int i = 0; i < `SRRS_SHADOW_NUM; i++) begin
         if (known_m[i]) rd_chk(32'h100 + 4 * i);
      end
      rd_chk(`SRRS_OFS_STAB);
      chk(stab_time_select, stab_m[2:0]);
      rd_chk(32'h200);
      bus(1'b0, `SRRS_OFS_PC, 32'h0);
      chk(rd, {16'h0, vec});
      bus(1'b0, `SRRS_OFS_STATUS, 32'h0);
      chk(rd[5:0], {2'b00, srrs_pkg::SRRS_RUN});
   endtask : chk_regs
   // ==========================================
   // sequencer checks
   task automatic chk_held(input logic hold);
      @(negedge core_clk);
      chk(system_reset, 1'b1);
      chk(pins_hiz, 1'b1);
      chk(cpu_run, 1'b0);
      chk(pc_valid, 1'b0);
      chk(ram_hold, hold);
      @(posedge core_clk);
   endtask : chk_held
   task automatic await_run(input int n, input int kind);
      int c;
      c = 0;
      while (osc_ready !== 1'b1) begin
         @(negedge core_clk);
         c++;
         if (c > 9000) give_up();
      end
      chk(pins_hiz, kind == 0);
      chk(pc_valid, kind != 0);
      c = 0;
      while (cpu_run !== 1'b1) begin
         @(negedge core_clk);
         c++;
         if (c > 9000) give_up();
      end
      chk_range(c, n, n + 6);
      chk(resume_next, kind == 1);
      chk(service_irq, kind == 2);
      chk(system_reset, 1'b0);
      chk(pc_valid, 1'b1);
      chk(program_counter, vec);
      @(posedge core_clk);
   endtask : await_run
   // ==========================================
   // main sequence
   initial begin
      core_clk = 1'b0;
      nrst = 1'b0;
      {hsel, hwrite, htrans, haddr, hwdata, wd_fire, irq_request} = '0;
      hsize = 3'h2;
      reset_pin_n = 1'b0;
      interrupt_mask_flag = 1'b1;
      interrupt_acknowledge_enable = 1'b0;
      start_delay = 4'h0;
      vec = $random(seed);
      model_reset();
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (PIN_MIN) @(posedge core_clk);
      chk_held(1'b0);
      reset_pin_n <= 1'b1;
      await_run(MID, 0);
      chk_regs();
      for (int i = 0; i < 30; i++) wr(32'h100 + 4 * i, $random(seed));
      wr(`SRRS_OFS_STAB, 32'h3);
      wr(`SRRS_OFS_STATUS, 32'hF);
      chk_regs();
      // wake from stop with every select code, service and resume
      for (int t = 0; t < 3; t++) begin
         wr(`SRRS_OFS_STAB, 2 * t);
         irq_request <= 1'b1;
         start_delay <= 4'($random(seed));
         wr(`SRRS_OFS_CMD, 32'h1);
         repeat (12) @(negedge core_clk);
         chk(osc_stop, 1'b1);
         chk(cpu_run, 1'b0);
         @(posedge core_clk);
         interrupt_mask_flag <= 1'b0;
         interrupt_acknowledge_enable <= t[0];
         await_run(t == 0 ? SHORT : (t == 1 ? MID : LONG), 1 + t[0]);
         irq_request <= 1'b0;
         interrupt_mask_flag <= 1'b1;
      end
      // watchdog overflow while running
      vec <= $random(seed);
      start_delay <= 4'hC;
      wd_fire <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk_held(1'b0);
      wd_fire <= 1'b0;
      model_reset();
      await_run(MID, 0);
      chk_regs();
      // reset pin while stopped
      vec <= $random(seed);
      wr(`SRRS_OFS_CMD, 32'h1);
      reset_pin_n <= 1'b0;
      repeat (PIN_MIN) @(posedge core_clk);
      chk_held(1'b1);
      reset_pin_n <= 1'b1;
      model_reset();
      await_run(MID, 0);
      chk_regs();
      conclude();
   end
endmodule : testbench
